// >>> rtl/tccu_pkg.sv
/*
  Shared constants for the timer capture/compare unit: register map,
  control field layout, mode codes and decode functions.
  Assumes a 32-bit APB slave with byte addresses in the low 8 bits.
*/
package tccu_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Register map (byte addresses)
  localparam int unsigned TCCU_AW = 8;
  localparam logic [1:0][7:0] OFS_VALUE_LOW = {8'h0c, 8'h00};
  localparam logic [1:0][7:0] OFS_VALUE_HIGH = {8'h10, 8'h04};
  localparam logic [1:0][7:0] OFS_CONTROL = {8'h14, 8'h08};
  localparam logic [7:0] OFS_SECOND_TIMER_CONTROL = 8'h18;
  localparam logic [7:0] OFS_EVENT_FLAGS = 8'h1c;
  localparam logic [7:0] OFS_EVENT_ENABLES = 8'h20;

  ////////////////////////////////////////////////////////////////////////
  // Field layout and reset values
  localparam int unsigned CONTROL_BITS = 6;
  localparam int unsigned MODE_LSB = 0;
  localparam int unsigned DUTY_LSB = 4;
  localparam int unsigned TIMER_SELECT_LOW_BIT = 3;
  localparam int unsigned TIMER_SELECT_HIGH_BIT = 6;
  localparam int unsigned SECOND_TIMER_CONTROL_BITS = 7;
  localparam logic [5:0] CONTROL_RESET = 6'h00;
  localparam logic [6:0] SECOND_TIMER_CONTROL_RESET = 7'h00;
  localparam logic [15:0] VALUE_RESET = 16'h0000;

  ////////////////////////////////////////////////////////////////////////
  // Mode codes
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_CMP_TOGGLE = 4'h2;
  localparam logic [3:0] MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE = 4'h5;
  localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
  localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
  localparam logic [3:0] MODE_CMP_SET = 4'h8;
  localparam logic [3:0] MODE_CMP_CLEAR = 4'h9;
  localparam logic [3:0] MODE_CMP_SOFT = 4'ha;
  localparam logic [3:0] MODE_CMP_TRIGGER = 4'hb;
  localparam logic [1:0] MODE_PWM_PREFIX = 2'h3;

  // Prescaler counts that complete every 4th and 16th rising edge
  localparam logic [3:0] PRESCALE_QUARTER = 4'h3;
  localparam logic [3:0] PRESCALE_SIXTEENTH = 4'hf;
  localparam int unsigned PWM_BITS = 10;

  ////////////////////////////////////////////////////////////////////////
  // Mode decode
  function automatic logic is_capture(input logic [3:0] mode);
    return mode[3:2] == 2'h1;
  endfunction

  function automatic logic is_compare(input logic [3:0] mode);
    return mode == MODE_CMP_TOGGLE || mode[3:2] == 2'h2;
  endfunction

  function automatic logic is_pwm(input logic [3:0] mode);
    return mode[3:2] == MODE_PWM_PREFIX;
  endfunction

  // High select hands both channels the second timer; low hands it
  // to the second channel only
  function automatic logic uses_second_timer(input logic [6:0] tctl,
                                             input logic chan);
    return tctl[TIMER_SELECT_HIGH_BIT] ||
           (chan && tctl[TIMER_SELECT_LOW_BIT]);
  endfunction

endpackage

// >>> rtl/tccu_chan_if.sv
/*
  Carrier between the register front end and one channel.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ns
interface tccu_chan_if;
  logic [3:0] mode;
  logic [1:0] duty_low;
  logic ctl_load;
  logic wr_low;
  logic wr_high;
  logic [7:0] wdata;
  logic [15:0] timer;
  logic pin_in;
  logic [15:0] value;
  logic pin_out;
  logic flag_set;
  logic trigger;

  modport ctl (
    output mode, duty_low, ctl_load, wr_low, wr_high, wdata, timer, pin_in,
    input value, pin_out, flag_set, trigger
  );

  modport chan (
    input mode, duty_low, ctl_load, wr_low, wr_high, wdata, timer, pin_in,
    output value, pin_out, flag_set, trigger
  );
endinterface

// >>> rtl/tccu_channel.sv
/*
  One capture/compare/PWM channel: 16-bit value register, capture edge
  prescaler, compare action on the output latch, simple 10-bit PWM.
  Assumes the pin input and the timer value are synchronous to clock.
*/
`timescale 1ns/1ns
module tccu_channel
  import tccu_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Front end
  tccu_chan_if.chan bus
);

  typedef struct packed {
    logic [15:0] value;
    logic [1:0] duty_frac;
    logic [PWM_BITS-1:0] pwm_count;
    logic [3:0] prescale;
    logic pin;
    logic pin_prev;
    logic match_prev;
  } tccu_chan_state_t;

  tccu_chan_state_t s;
  tccu_chan_state_t next_s;
  logic rise;
  logic fall;
  logic hit;
  logic fire;
  logic take;

  assign rise = bus.pin_in && !s.pin_prev;
  assign fall = !bus.pin_in && s.pin_prev;
  assign hit = s.value == bus.timer;
  // Act once per match so a stalled timer does not retrigger each cycle
  assign fire = is_compare(bus.mode) && hit && !s.match_prev;

  always_comb begin
    take = 1'b0;
    unique case (bus.mode)
      MODE_CAP_FALL: take = fall;
      MODE_CAP_RISE: take = rise;
      MODE_CAP_RISE4: take = rise && s.prescale[1:0] == PRESCALE_QUARTER[1:0];
      MODE_CAP_RISE16: take = rise && s.prescale == PRESCALE_SIXTEENTH;
      default: take = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_s = s;
    next_s.pin_prev = bus.pin_in;
    next_s.match_prev = hit && is_compare(bus.mode);
    // The count survives a switch between capture settings, so the
    // first capture after such a switch may come early
    if (!is_capture(bus.mode)) begin
      next_s.prescale = 4'h0;
    end else if (rise) begin
      next_s.prescale = s.prescale + 4'h1;
    end
    if (bus.wr_low) begin
      next_s.value[7:0] = bus.wdata;
    end
    // Upper byte is the duty latch while in PWM, so software cannot write it
    if (bus.wr_high && !is_pwm(bus.mode)) begin
      next_s.value[15:8] = bus.wdata;
    end
    if (take) begin
      next_s.value = bus.timer;
    end
    if (fire) begin
      unique case (bus.mode)
        MODE_CMP_TOGGLE: next_s.pin = !s.pin;
        MODE_CMP_SET: next_s.pin = 1'b1;
        MODE_CMP_CLEAR: next_s.pin = 1'b0;
        default: next_s.pin = s.pin;
      endcase
    end
    if (is_pwm(bus.mode)) begin
      next_s.pwm_count = s.pwm_count + 10'h001;
      // Duty reloads only at the period end to avoid glitches
      if (s.pwm_count == '1) begin
        next_s.value[15:8] = s.value[7:0];
        next_s.duty_frac = bus.duty_low;
      end
      // Compare against the duty that holds for the new count, so the
      // first cycle of a period already follows a fresh reload
      next_s.pin =
        {next_s.value[15:8], next_s.duty_frac} > next_s.pwm_count;
    end else begin
      next_s.pwm_count = '0;
    end
    if (bus.ctl_load) begin
      unique case (bus.wdata[3:0])
        MODE_OFF: next_s.pin = 1'b0;
        MODE_CMP_SET: next_s.pin = 1'b0;
        MODE_CMP_CLEAR: next_s.pin = 1'b1;
        default: next_s.pin = next_s.pin;
      endcase
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      s <= '{value: VALUE_RESET, default: '0};
    end else begin
      s <= next_s;
    end
  end

  assign bus.value = s.value;
  assign bus.pin_out = s.pin;
  assign bus.flag_set = take || fire;
  assign bus.trigger = fire && bus.mode == MODE_CMP_TRIGGER;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  AST_PRESCALE_CLEAR: assert property (
    !is_capture(bus.mode) |=> s.prescale == 4'h0)
    else $error("prescaler not cleared outside capture");

  AST_CAPTURE_RISE: assert property (
    bus.mode == MODE_CAP_RISE && bus.pin_in && !s.pin_prev
    |-> bus.flag_set ##1 s.value == $past(bus.timer))
    else $error("rising edge capture missed");

  AST_CAPTURE_SIXTEENTH: assert property (
    bus.mode == MODE_CAP_RISE16 && rise && s.prescale != 4'hf
    |-> !bus.flag_set)
    else $error("capture before sixteenth edge");

  AST_COMPARE_FLAG: assert property (
    is_compare(bus.mode) && hit && !s.match_prev |-> bus.flag_set)
    else $error("compare match raised no flag");

  AST_TOGGLE: assert property (
    bus.mode == MODE_CMP_TOGGLE && fire && !bus.ctl_load
    |=> s.pin != $past(s.pin))
    else $error("toggle did not toggle");

  AST_SOFT_ONLY: assert property (
    bus.mode == MODE_CMP_SOFT && !bus.ctl_load |=> $stable(s.pin))
    else $error("pin moved in software compare mode");

  AST_OFF_LOW: assert property (
    bus.ctl_load && bus.wdata[3:0] == MODE_OFF |=> !bus.pin_out)
    else $error("output latch not low after clear");

  AST_PWM_START: assert property (
    is_pwm(bus.mode) && s.pwm_count == '1 && s.value[7:0] != 8'h00
    && !bus.ctl_load |=> bus.pin_out)
    else $error("pwm period did not start high");

endmodule

// >>> rtl/tccu_top.sv
/*
  Timer capture/compare unit with two channels behind an APB slave.
  Assumes the two 16-bit timers and their counting live outside; this
  block reads their values and pulses their clear inputs.
*/
// Chosen here: the register addresses and the APB slave port.
// Operation
// - Capture copies selected timer into value register and sets the sticky flag
// - Capture codes 0100-0111: falling, rising, 4th rising, 16th rising
// - Codes 0010 toggle, 1000 start low set high, 1001 start high set low
// - 1010 flag only, 1011 trigger, 11xx PWM, 0000 off and reset
// - Timer choice per channel comes from second timer control bits
// - Changing capture mode may set a false flag; software masks it
// - Prescaler counter cleared whenever channel is not capturing
// - Switching prescaler setting keeps the count; early capture possible
// - Compare mode matches value against selected timer continuously
// - Compare match sets flag in the same cycle as pin action
// - Writing zero to control forces the compare latch low
// - Software-interrupt compare leaves pin alone; request only if enabled
// - First channel trigger clears the first timer, giving a period, unless the high select bit gives it the second timer
// - A channel trigger clears whichever timer it selected
// - Second channel trigger starts conversion only if converter enabled
// - Second channel trigger clearing a timer sets no timer flag
// - PWM output has at most 10-bit duty resolution
// - Writing zero to control forces the PWM latch low
`timescale 1ns/1ns
module tccu_top
  import tccu_pkg::*;
(
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RESET,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [TCCU_AW-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Timers
  input wire logic [15:0] FIRST_TIMER,
  input wire logic [15:0] SECOND_TIMER,
  output logic FIRST_TIMER_RESET,
  output logic SECOND_TIMER_RESET,
  output logic TIMER_FLAG_HOLD,
  // Converter
  input wire logic ADC_ENABLED,
  output logic ADC_START,
  // Channel pins and requests
  input wire logic CHAN1_PIN_IN,
  input wire logic CHAN2_PIN_IN,
  output logic CHAN1_PIN_OUT,
  output logic CHAN2_PIN_OUT,
  output logic CHAN1_REQUEST,
  output logic CHAN2_REQUEST
);

  typedef struct packed {
    logic [1:0][CONTROL_BITS-1:0] control;
    logic [SECOND_TIMER_CONTROL_BITS-1:0] second_timer_control;
    logic [1:0] event_flag;
    logic [1:0] event_enable;
    logic [31:0] rdata;
  } tccu_top_state_t;

  tccu_top_state_t s;
  tccu_top_state_t next_s;
  tccu_chan_if ch [2] ();
  logic [1:0] pin_in;
  logic [1:0] pin_out;
  logic [1:0] flag_set;
  logic [1:0] trigger;
  logic [1:0] select_second;
  logic [1:0][15:0] value;
  logic access;
  logic wr;
  logic mapped;

  assign pin_in = {CHAN2_PIN_IN, CHAN1_PIN_IN};
  assign access = PSEL && PENABLE;
  assign wr = access && PWRITE;

  function automatic logic decoded(input logic [7:0] addr);
    return addr == OFS_VALUE_LOW[0] || addr == OFS_VALUE_LOW[1] ||
           addr == OFS_VALUE_HIGH[0] || addr == OFS_VALUE_HIGH[1] ||
           addr == OFS_CONTROL[0] || addr == OFS_CONTROL[1] ||
           addr == OFS_SECOND_TIMER_CONTROL ||
           addr == OFS_EVENT_FLAGS || addr == OFS_EVENT_ENABLES;
  endfunction

  assign mapped = decoded(PADDR);

  ////////////////////////////////////////////////////////////////////////
  // Channels
  for (genvar i = 0; i < 2; i++) begin : g_chan
    assign select_second[i] =
      uses_second_timer(s.second_timer_control, 1'(i));
    assign ch[i].mode = s.control[i][MODE_LSB +: 4];
    assign ch[i].duty_low = s.control[i][DUTY_LSB +: 2];
    assign ch[i].ctl_load = wr && PADDR == OFS_CONTROL[i];
    assign ch[i].wr_low = wr && PADDR == OFS_VALUE_LOW[i];
    assign ch[i].wr_high = wr && PADDR == OFS_VALUE_HIGH[i];
    assign ch[i].wdata = PWDATA[7:0];
    assign ch[i].timer = select_second[i] ? SECOND_TIMER : FIRST_TIMER;
    assign ch[i].pin_in = pin_in[i];
    assign value[i] = ch[i].value;
    assign pin_out[i] = ch[i].pin_out;
    assign flag_set[i] = ch[i].flag_set;
    assign trigger[i] = ch[i].trigger;

    tccu_channel u_channel (
      .clock(CLOCK),
      .reset(RESET),
      .bus(ch[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers
  always_comb begin
    next_s = s;
    if (PSEL && !PENABLE) begin
      next_s.rdata = 32'h0000_0000;
      for (int i = 0; i < 2; i++) begin
        if (PADDR == OFS_VALUE_LOW[i]) begin
          next_s.rdata[7:0] = value[i][7:0];
        end
        if (PADDR == OFS_VALUE_HIGH[i]) begin
          next_s.rdata[7:0] = value[i][15:8];
        end
        if (PADDR == OFS_CONTROL[i]) begin
          next_s.rdata[CONTROL_BITS-1:0] = s.control[i];
        end
      end
      if (PADDR == OFS_SECOND_TIMER_CONTROL) begin
        next_s.rdata[SECOND_TIMER_CONTROL_BITS-1:0] = s.second_timer_control;
      end
      if (PADDR == OFS_EVENT_FLAGS) begin
        next_s.rdata[1:0] = s.event_flag;
      end
      if (PADDR == OFS_EVENT_ENABLES) begin
        next_s.rdata[1:0] = s.event_enable;
      end
    end
    for (int i = 0; i < 2; i++) begin
      if (wr && PADDR == OFS_CONTROL[i]) begin
        next_s.control[i] = PWDATA[CONTROL_BITS-1:0];
      end
    end
    if (wr && PADDR == OFS_SECOND_TIMER_CONTROL) begin
      next_s.second_timer_control = PWDATA[SECOND_TIMER_CONTROL_BITS-1:0];
    end
    if (wr && PADDR == OFS_EVENT_ENABLES) begin
      next_s.event_enable = PWDATA[1:0];
    end
    // Write one to clear; a new event in the same cycle wins.
    // A mode change may leave a false flag here for software to clear.
    if (wr && PADDR == OFS_EVENT_FLAGS) begin
      next_s.event_flag = s.event_flag & ~PWDATA[1:0];
    end
    next_s.event_flag = next_s.event_flag | flag_set;
  end

  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      s <= '{control: {CONTROL_RESET, CONTROL_RESET},
             second_timer_control: SECOND_TIMER_CONTROL_RESET,
             default: '0};
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  assign PRDATA = s.rdata;
  assign PREADY = 1'b1;
  assign PSLVERR = access && !mapped;
  assign CHAN1_PIN_OUT = pin_out[0];
  assign CHAN2_PIN_OUT = pin_out[1];
  assign CHAN1_REQUEST = s.event_flag[0] && s.event_enable[0];
  assign CHAN2_REQUEST = s.event_flag[1] && s.event_enable[1];
  assign FIRST_TIMER_RESET = |(trigger & ~select_second);
  assign SECOND_TIMER_RESET = |(trigger & select_second);
  assign TIMER_FLAG_HOLD = trigger[1];
  assign ADC_START = trigger[1] && ADC_ENABLED;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (RESET);

  AST_FLAG_SET_WINS: assert property (
    flag_set[0] |=> s.event_flag[0])
    else $error("event flag lost");

  AST_FLAG_STICKY: assert property (
    s.event_flag[1] && !(wr && PADDR == OFS_EVENT_FLAGS)
    |=> s.event_flag[1])
    else $error("event flag cleared without software");

  AST_FIRST_PERIOD: assert property (
    trigger[0] && !trigger[1] &&
    !s.second_timer_control[TIMER_SELECT_HIGH_BIT]
    |-> FIRST_TIMER_RESET && !SECOND_TIMER_RESET)
    else $error("first channel trigger missed first timer");

  AST_CONVERT: assert property (
    ADC_START |-> trigger[1] && ADC_ENABLED)
    else $error("conversion started without cause");

  AST_NO_TIMER_FLAG: assert property (
    trigger[1] |-> TIMER_FLAG_HOLD)
    else $error("timer flag not held on trigger");

  AST_SELECT_SECOND: assert property (
    s.second_timer_control[TIMER_SELECT_HIGH_BIT]
    |-> select_second == 2'h3)
    else $error("timer select not honoured");

  AST_FLAG2_SET_WINS: assert property (
    flag_set[1] |=> s.event_flag[1])
    else $error("second event flag lost");

  AST_FLAG1_STICKY: assert property (
    s.event_flag[0] && !(wr && PADDR == OFS_EVENT_FLAGS)
    |=> s.event_flag[0])
    else $error("first event flag cleared without software");

  AST_FLAG_CLEAR: assert property (
    wr && PADDR == OFS_EVENT_FLAGS && PWDATA[0] && !flag_set[0]
    |=> !s.event_flag[0])
    else $error("event flag ignored its clear");

  AST_REQUEST1: assert property (
    flag_set[0] && s.event_enable[0] && !(wr && PADDR == OFS_EVENT_ENABLES)
    |=> CHAN1_REQUEST)
    else $error("enabled event raised no request");

  AST_REQUEST2: assert property (
    flag_set[1] && s.event_enable[1] && !(wr && PADDR == OFS_EVENT_ENABLES)
    |=> CHAN2_REQUEST)
    else $error("enabled second event raised no request");

  AST_OFF1_LOW: assert property (
    wr && PADDR == OFS_CONTROL[0] && PWDATA[3:0] == MODE_OFF
    |=> !CHAN1_PIN_OUT)
    else $error("first pin not low after clear");

  AST_OFF2_LOW: assert property (
    wr && PADDR == OFS_CONTROL[1] && PWDATA[3:0] == MODE_OFF
    |=> !CHAN2_PIN_OUT)
    else $error("second pin not low after clear");

  AST_OFF_QUIET: assert property (
    s.control[0][3:0] == MODE_OFF |-> !flag_set[0] && !trigger[0])
    else $error("channel off raised an event");

  AST_OFF2_QUIET: assert property (
    s.control[1][3:0] == MODE_OFF |-> !flag_set[1] && !trigger[1])
    else $error("second channel off raised an event");

  AST_TRIGGER_MODE: assert property (
    trigger[0] |-> s.control[0][3:0] == MODE_CMP_TRIGGER)
    else $error("trigger outside trigger mode");

  AST_TRIGGER_FLAG: assert property (
    trigger[0] |-> flag_set[0])
    else $error("trigger raised no flag");

  AST_TRIGGER2_FLAG: assert property (
    trigger[1] |-> flag_set[1] && s.control[1][3:0] == MODE_CMP_TRIGGER)
    else $error("second trigger out of mode or without flag");

  AST_PWM_QUIET: assert property (
    is_pwm(s.control[0][3:0]) |-> !flag_set[0])
    else $error("pwm raised an event");

  AST_SECOND_CLEAR: assert property (
    trigger[1] && !trigger[0]
    |-> (select_second[1] ? SECOND_TIMER_RESET : FIRST_TIMER_RESET))
    else $error("second trigger cleared the wrong timer");

  AST_SELECT_LOW: assert property (
    s.second_timer_control[TIMER_SELECT_LOW_BIT]
    |-> select_second[1])
    else $error("second channel not on second timer");

  AST_SELECT_FIRST: assert property (
    !s.second_timer_control[TIMER_SELECT_HIGH_BIT] |-> !select_second[0])
    else $error("first channel left first timer");

  AST_READ_FLAGS: assert property (
    PSEL && !PENABLE && PADDR == OFS_EVENT_FLAGS
    |=> PRDATA[1:0] == $past(s.event_flag))
    else $error("flag read returned a stale value");

  AST_UNMAPPED_WRITE: assert property (
    wr && !mapped |=> $stable(s.control))
    else $error("unmapped write changed a control");

endmodule

// >>> dv/tccu_timer_model.sv
/*
  Model of the two 16-bit timers that feed the unit.
  Assumes clear pulses arrive synchronous to the clock.
*/
`timescale 1ns/1ns
module tccu_timer_model #(
  parameter logic [15:0] SECOND_START = 16'h8000
) (
  // Clock and control
  input wire logic clock,
  input wire logic reset,
  input wire logic run,
  // Clears from the triggers
  input wire logic clear1,
  input wire logic clear2,
  // Timer values
  output logic [15:0] timer1,
  output logic [15:0] timer2
);
  // Counts on the system clock only, never asynchronously
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      timer1 <= 16'h0000;
      timer2 <= SECOND_START;
    end else begin
      // A trigger clear is not an overflow, so no flag would follow
      if (clear1) timer1 <= 16'h0000;
      else if (run) timer1 <= timer1 + 16'h0001;
      if (clear2) timer2 <= 16'h0000;
      else if (run) timer2 <= timer2 + 16'h0001;
    end
  end
endmodule

// >>> dv/tccu_top_tb.sv
/*
  Self-checking bench for the capture/compare unit.
  Assumes the timer model in dv and an APB master in this bench.
*/
`timescale 1ns/1ns
module tccu_top_tb
  import tccu_pkg::*;
;
  `define CHK(got, exp) begin \
    n_checks++; \
    if ((got) !== (exp)) begin \
      fails++; \
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); \
    end \
  end

  logic clock = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err;
  logic [15:0] t1, t2;
  logic r1, r2, hold, adc_start;
  logic adc_en = 1'b0, run = 1'b1;
  logic [1:0] pin = 2'h0, pout, req;
  logic s1 = 1'b0, s2 = 1'b0, sa = 1'b0, sh = 1'b0;
  logic [7:0] v8;
  logic [9:0] d;
  int fails = 0, n_checks = 0, seed = 42613, hi;

  always #25 clock = ~clock;

  tccu_top dut_u (
    .CLOCK(clock), .RESET(reset),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .FIRST_TIMER(t1), .SECOND_TIMER(t2),
    .FIRST_TIMER_RESET(r1), .SECOND_TIMER_RESET(r2),
    .TIMER_FLAG_HOLD(hold), .ADC_ENABLED(adc_en), .ADC_START(adc_start),
    .CHAN1_PIN_IN(pin[0]), .CHAN2_PIN_IN(pin[1]),
    .CHAN1_PIN_OUT(pout[0]), .CHAN2_PIN_OUT(pout[1]),
    .CHAN1_REQUEST(req[0]), .CHAN2_REQUEST(req[1])
  );

  tccu_timer_model tm_u (
    .clock(clock), .reset(reset), .run(run), .clear1(r1), .clear2(r2),
    .timer1(t1), .timer2(t2)
  );

  // Trigger pulses last one cycle, so hold them for the case in hand
  always @(posedge clock) begin
    if (r1) s1 <= 1'b1;
    if (r2) s2 <= 1'b1;
    if (adc_start) sa <= 1'b1;
    if (hold) sh <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] dat);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= dat;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic pulse(input int c);
    @(posedge clock);
    pin[c] <= 1'b1;
    repeat (2) @(posedge clock);
    pin[c] <= 1'b0;
    repeat (2) @(posedge clock);
  endtask

  function automatic int need(input logic [3:0] m);
    return m == MODE_CAP_RISE4 ? 4 : m == MODE_CAP_RISE16 ? 16 : 1;
  endfunction

  function automatic logic sel2(input int c, input logic [7:0] ts);
    return ts[6] || (c == 1 && ts[3]);
  endfunction

  task automatic cap(input int c, input logic [3:0] m);
    logic [15:0] e;
    apb(1'b1, OFS_CONTROL[c], 32'h0);
    apb(1'b1, OFS_CONTROL[c], {28'h0, m});
    apb(1'b1, OFS_EVENT_FLAGS, 32'h3);
    // Timers have stopped by now, so the expected value is settled
    e = sel2(c, 8'h08) ? t2 : t1;
    repeat (need(m) - 1) pulse(c);
    apb(1'b0, OFS_EVENT_FLAGS, 32'h0);
    `CHK(rd[c], 1'b0)
    pulse(c);
    apb(1'b0, OFS_EVENT_FLAGS, 32'h0);
    `CHK(rd[c], 1'b1)
    apb(1'b0, OFS_VALUE_LOW[c], 32'h0);
    `CHK(rd, {24'h0, e[7:0]})
    apb(1'b0, OFS_VALUE_HIGH[c], 32'h0);
    `CHK(rd, {24'h0, e[15:8]})
    `CHK(req[c], 1'b1)
    apb(1'b1, OFS_EVENT_ENABLES, 32'h0);
    tick(1);
    `CHK(req[c], 1'b0)
    apb(1'b1, OFS_EVENT_ENABLES, 32'h3);
    apb(1'b1, OFS_EVENT_FLAGS, 32'h1 << c);
    apb(1'b0, OFS_EVENT_FLAGS, 32'h0);
    `CHK(rd[c], 1'b0)
  endtask

  task automatic cmp(input int c, input logic [3:0] pre, m,
                     input logic [7:0] ts, input logic ae, ep,
                     input logic [3:0] es);
    logic [15:0] v;
    int i;
    apb(1'b1, OFS_CONTROL[0], 32'h0);
    apb(1'b1, OFS_CONTROL[1], 32'h0);
    tick(1);
    `CHK(pout[c], 1'b0)
    apb(1'b1, OFS_SECOND_TIMER_CONTROL, {24'h0, ts});
    adc_en <= ae;
    run <= 1'b0;
    tick(1);
    v = (sel2(c, ts) ? t2 : t1) + 16'(4 + ($random(seed) & 15));
    apb(1'b1, OFS_VALUE_LOW[c], {24'h0, v[7:0]});
    apb(1'b1, OFS_VALUE_HIGH[c], {24'h0, v[15:8]});
    apb(1'b1, OFS_CONTROL[c], {28'h0, pre});
    apb(1'b1, OFS_CONTROL[c], {28'h0, m});
    apb(1'b1, OFS_EVENT_FLAGS, 32'h3);
    tick(1);
    `CHK(pout[c], pre == MODE_CMP_CLEAR || m == MODE_CMP_CLEAR)
    {s1, s2, sa, sh} = 4'h0;
    @(posedge clock);
    run <= 1'b1;
    i = 0;
    do begin
      apb(1'b0, OFS_EVENT_FLAGS, 32'h0);
      i++;
    end while (rd[c] !== 1'b1 && i < 20);
    tick(2);
    `CHK(rd[c], 1'b1)
    if (m != MODE_CMP_TRIGGER) `CHK(pout[c], ep)
    `CHK({s1, s2, sa, sh}, es)
    `CHK(req[c], 1'b1)
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    apb(1'b0, OFS_CONTROL[0], 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b0, OFS_SECOND_TIMER_CONTROL, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b1, OFS_CONTROL[1], 32'hff);
    apb(1'b0, OFS_CONTROL[1], 32'h0);
    `CHK(rd, 32'h3f)
    apb(1'b1, 8'h40, 32'h5a);
    `CHK(err, 1'b1)
    v8 = 8'($random(seed));
    apb(1'b1, OFS_VALUE_HIGH[0], {24'h0, v8});
    apb(1'b0, OFS_VALUE_HIGH[0], 32'h0);
    `CHK(rd, {24'h0, v8})
    $display("registers done");
    apb(1'b1, OFS_SECOND_TIMER_CONTROL, 32'h08);
    apb(1'b1, OFS_EVENT_ENABLES, 32'h3);
    repeat (16 + ($random(seed) & 255)) @(posedge clock);
    run <= 1'b0;
    for (int c = 0; c < 2; c++)
      for (int m = 4; m < 8; m++) cap(c, 4'(m));
    $display("capture modes done");
    apb(1'b1, OFS_CONTROL[0], 32'h0);
    apb(1'b1, OFS_CONTROL[0], {28'h0, MODE_CAP_RISE16});
    repeat (3) pulse(0);
    apb(1'b1, OFS_CONTROL[0], {28'h0, MODE_CAP_RISE4});
    apb(1'b1, OFS_EVENT_FLAGS, 32'h3);
    pulse(0);
    apb(1'b0, OFS_EVENT_FLAGS, 32'h0);
    `CHK(rd[0], 1'b1)
    pulse(0);
    apb(1'b1, OFS_CONTROL[0], 32'h0);
    apb(1'b1, OFS_CONTROL[0], {28'h0, MODE_CAP_RISE4});
    apb(1'b1, OFS_EVENT_FLAGS, 32'h3);
    repeat (3) pulse(0);
    apb(1'b0, OFS_EVENT_FLAGS, 32'h0);
    `CHK(rd[0], 1'b0)
    $display("prescaler done");
    cmp(0, 4'h0, MODE_CMP_SET, 8'h00, 1'b0, 1'b1, 4'h0);
    cmp(0, 4'h0, MODE_CMP_CLEAR, 8'h00, 1'b0, 1'b0, 4'h0);
    cmp(0, 4'h9, MODE_CMP_TOGGLE, 8'h00, 1'b0, 1'b0, 4'h0);
    cmp(0, 4'h9, MODE_CMP_SOFT, 8'h00, 1'b0, 1'b1, 4'h0);
    cmp(0, 4'h0, MODE_CMP_TRIGGER, 8'h00, 1'b0, 1'b0, 4'h8);
    cmp(0, 4'h0, MODE_CMP_TRIGGER, 8'h40, 1'b0, 1'b0, 4'h4);
    cmp(1, 4'h0, MODE_CMP_TRIGGER, 8'h08, 1'b1, 1'b0, 4'h7);
    cmp(1, 4'h0, MODE_CMP_TRIGGER, 8'h00, 1'b0, 1'b0, 4'h9);
    cmp(1, 4'h0, MODE_CMP_SET, 8'h08, 1'b0, 1'b1, 4'h0);
    $display("compare modes done");
    d = 10'($random(seed));
    apb(1'b1, OFS_CONTROL[0], 32'h0);
    apb(1'b1, OFS_VALUE_LOW[0], {24'h0, d[9:2]});
    apb(1'b1, OFS_CONTROL[0], {26'h0, d[1:0], 4'hc});
    tick(1100);
    hi = 0;
    repeat (1024) begin
      tick(1);
      hi += int'(pout[0] === 1'b1);
    end
    `CHK(hi, int'(d))
    apb(1'b1, OFS_CONTROL[0], 32'h0);
    tick(1);
    `CHK(pout[0], 1'b0)
    $display("pwm done");
    end_of_test;
  end

  // The whole run needs about 3300 cycles
  initial begin
    #(50 * 40000);
    fails++;
    end_of_test;
  end
endmodule
